// ---- tps_pkg.sv ----
// package for the typewriter print sequencer
package tps_pkg;
    localparam int TPS_CODE_W = 6;
    localparam int TPS_FIFO_DEPTH = 32;
    localparam logic [5:0] TPS_CODE_CR = 6'h25;
    localparam logic [5:0] TPS_CODE_TAB = 6'h29;
    localparam logic [5:0] TPS_CODE_SPACE = 6'h04;
    localparam logic [5:0] TPS_CODE_SHIFT_UP = 6'h27;
    localparam logic [5:0] TPS_CODE_SHIFT_DOWN = 6'h2f;
    localparam logic [5:0] TPS_CODE_BACK_SPACE = 6'h31;
    localparam logic [5:0] TPS_CODE_COLOR = 6'h02;
    localparam logic [5:0] TPS_CODE_ZERO = 6'h00;
    localparam logic [63:0] TPS_VALID_MAP = 64'h1557_d7f4_ffff_fefe;

    typedef enum logic [6:0] {
        TPS_IDLE = 7'h01,
        TPS_WAIT_RC = 7'h02,
        TPS_CLASSIFY = 7'h04,
        TPS_CHAR = 7'h08,
        TPS_FUNC = 7'h10,
        TPS_IMPOSS = 7'h20,
        TPS_DONE = 7'h40
    } tps_state_t;

    typedef struct packed {
        logic reader_common;
        logic cr_contact;
        logic fault_clear;
    } tps_contacts_t;

    typedef struct packed {
        logic reader_clutch;
        logic translator_clutch;
        logic solenoids;
        logic char_ack;
        logic ack1;
        logic ack2;
        logic detect_en;
    } tps_drive_t;
endpackage

// ---- tps_sync.sv ----
// two-flop synchroniser for contact inputs
`timescale 1ns/1ps
`default_nettype none
module tps_sync import tps_pkg::*; #(
    parameter int W = 3
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// ---- tps_fifo.sv ----
// print command fifo, parameterised width and depth
`timescale 1ns/1ps
`default_nettype none
module tps_fifo import tps_pkg::*; #(
    parameter int WIDTH = TPS_CODE_W,
    parameter int DEPTH = TPS_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic do_wr;
    logic do_rd;
    assign next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            count <= next_count;
            // registered ready already accounts for this edge's write and read
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end
endmodule
`default_nettype wire

// ---- tps_sequencer.sv ----
// typewriter print sequencer top
`timescale 1ns/1ps
`default_nettype none
// Contract
// RQ1: on print command latch X bits 0..5 into print code register, energise reader clutch
// RQ2: typewriter starts a cycle after clutch; cycle start closes reader common contacts
// RQ3: reader common close enables detection, translator clutch, solenoids, character acknowledge
// RQ4: classify code: plain character, function, or impossible print
// RQ5: codes outside the typewriter set are invalid and go to impossible print
// RQ6: character path covers all but carriage return, tab, invalid codes
// RQ7: character acknowledge drops ack I, which drops ack II, clears register, releases clutch
// RQ8: no new typewriter cycle until a new print command arrives
// RQ9: reader common reopening drops translator clutch, character acknowledge, detection enable
// RQ10: character acknowledge drop reasserts ack I, ack II and one completion pulse
// RQ11: function path only for carriage return and tab
// RQ12: function state latched through carriage return contact, blocks completion pulse
// RQ13: function path: ack I returns after ack drop and contact reclose; state clears on open
// RQ14: impossible print holds ack I, keeps register, no pulse, releases clutch
// RQ15: impossible print raises fault causing class A stop
// RQ16: after impossible print wait for external fault clear and new command
// RQ17: codes: return 45, tab 51, space 04, up 47, down 57, back 61, color 02 octal
// RQ18: contacts synchronised; one state machine returning to idle after completion
module tps_sequencer import tps_pkg::*; (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic print_cmd_valid,
    output logic print_cmd_ready,
    input wire logic [TPS_CODE_W-1:0] x_code,
    input wire tps_contacts_t contacts,
    output tps_drive_t drive,
    output logic [TPS_CODE_W-1:0] print_code_register,
    output logic typewriter_done_pulse,
    output logic impossible_fault,
    output logic function_state
);
    tps_contacts_t sync_c;
    tps_state_t state;
    tps_state_t next_state;
    logic q_valid;
    logic q_ready;
    logic [TPS_CODE_W-1:0] q_code;
    logic fifo_in_ready;
    logic rc_prev;
    logic cr_prev;
    logic rc_rise;
    logic rc_fall;
    logic cr_rise;
    logic cr_fall;
    logic is_func;
    logic is_valid;
    logic char_ack_dropped;
    logic cr_opened;

    // contact inputs pass two flops first [RQ18]
    tps_sync #(.W(3)) u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .async_in(contacts),
        .sync_out(sync_c)
    );

    tps_fifo #(.WIDTH(TPS_CODE_W), .DEPTH(TPS_FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .in_valid(print_cmd_valid),
        .in_ready(fifo_in_ready),
        .in_data(x_code),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_code)
    );

    // only pop a command in idle with no fault held [RQ8] [RQ16]
    assign q_ready = (state == TPS_IDLE) && !impossible_fault;

    // code classification [RQ4] [RQ5] [RQ11] [RQ17]
    assign is_func = (print_code_register == TPS_CODE_CR) || (print_code_register == TPS_CODE_TAB);
    assign is_valid = TPS_VALID_MAP[print_code_register];

    assign rc_rise = sync_c.reader_common && !rc_prev;
    assign rc_fall = !sync_c.reader_common && rc_prev;
    assign cr_rise = sync_c.cr_contact && !cr_prev;
    assign cr_fall = !sync_c.cr_contact && cr_prev;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rc_prev <= 1'b0;
            cr_prev <= 1'b0;
        end else begin
            rc_prev <= sync_c.reader_common;
            cr_prev <= sync_c.cr_contact;
        end
    end

    // fifo ready is a flop that already counts this edge's write
    assign print_cmd_ready = fifo_in_ready;

    // state machine
    always_comb begin
        next_state = state;
        case (state)
            TPS_IDLE: begin
                if (q_valid && !impossible_fault) begin
                    next_state = TPS_WAIT_RC;
                end
            end
            TPS_WAIT_RC: begin
                if (rc_rise) begin
                    next_state = TPS_CLASSIFY;
                end
            end
            TPS_CLASSIFY: begin
                if (!is_valid) begin
                    next_state = TPS_IMPOSS; // [RQ5]
                end else if (is_func) begin
                    next_state = TPS_FUNC; // [RQ11]
                end else begin
                    next_state = TPS_CHAR; // [RQ6]
                end
            end
            TPS_CHAR: begin
                if (char_ack_dropped) begin
                    next_state = TPS_DONE; // [RQ10]
                end
            end
            TPS_FUNC: begin
                if (char_ack_dropped && cr_opened && cr_rise) begin
                    next_state = TPS_DONE; // [RQ13]
                end
            end
            TPS_IMPOSS: begin
                if (sync_c.fault_clear) begin
                    next_state = TPS_IDLE; // [RQ16]
                end
            end
            TPS_DONE: begin
                next_state = TPS_IDLE; // [RQ18]
            end
            default: begin
                next_state = TPS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state <= TPS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // print code register and reader clutch [RQ1] [RQ7] [RQ14]
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            print_code_register <= TPS_CODE_ZERO;
            drive.reader_clutch <= 1'b0;
        end else if (state == TPS_IDLE && next_state == TPS_WAIT_RC) begin
            print_code_register <= q_code; // [RQ1]
            drive.reader_clutch <= 1'b1;
        end else if (state == TPS_CLASSIFY && !is_valid) begin
            drive.reader_clutch <= 1'b0; // [RQ14]
        end else if ((state == TPS_CHAR || state == TPS_FUNC) && drive.char_ack && drive.ack1) begin
            print_code_register <= TPS_CODE_ZERO; // [RQ7]
            drive.reader_clutch <= 1'b0;
        end
    end

    // translator drive and detection follow reader common [RQ3] [RQ9]
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            drive.translator_clutch <= 1'b0;
            drive.solenoids <= 1'b0;
            drive.char_ack <= 1'b0;
            drive.detect_en <= 1'b0;
        end else if (state == TPS_WAIT_RC && rc_rise) begin
            drive.translator_clutch <= 1'b1; // [RQ3]
            drive.solenoids <= 1'b1;
            drive.char_ack <= 1'b1;
            drive.detect_en <= 1'b1;
        end else if (rc_fall || state == TPS_IDLE) begin
            drive.translator_clutch <= 1'b0; // [RQ9]
            drive.solenoids <= 1'b0;
            drive.char_ack <= 1'b0;
            drive.detect_en <= 1'b0;
        end
    end

    // acknowledge I and II
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            drive.ack1 <= 1'b1;
            drive.ack2 <= 1'b1;
        end else if (state == TPS_IMPOSS) begin
            drive.ack1 <= 1'b1; // [RQ14]
            drive.ack2 <= 1'b1;
        end else if ((state == TPS_CHAR || state == TPS_FUNC) && drive.char_ack) begin
            drive.ack1 <= 1'b0; // [RQ7]
            drive.ack2 <= 1'b0;
        end else if (next_state == TPS_DONE) begin
            drive.ack1 <= 1'b1; // [RQ10] [RQ13]
            drive.ack2 <= 1'b1;
        end
    end

    // remembers the acknowledge drop and the carriage contact opening
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            char_ack_dropped <= 1'b0;
            cr_opened <= 1'b0;
        end else if (state == TPS_IDLE) begin
            char_ack_dropped <= 1'b0;
            cr_opened <= 1'b0;
        end else begin
            if (rc_fall) begin
                char_ack_dropped <= 1'b1;
            end
            if (cr_fall) begin
                cr_opened <= 1'b1;
            end
        end
    end

    // function state held through carriage contact [RQ12] [RQ13]
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            function_state <= 1'b0;
        end else if (state == TPS_CLASSIFY && is_valid && is_func) begin
            function_state <= 1'b1;
        end else if (cr_fall) begin
            function_state <= 1'b0;
        end
    end

    // completion pulse, blocked by function state or fault [RQ10] [RQ12] [RQ14]
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            typewriter_done_pulse <= 1'b0;
        end else begin
            typewriter_done_pulse <= (next_state == TPS_DONE) && !function_state && !impossible_fault;
        end
    end

    // impossible print fault, cleared externally [RQ15] [RQ16]
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            impossible_fault <= 1'b0;
        end else if (state == TPS_CLASSIFY && !is_valid) begin
            impossible_fault <= 1'b1;
        end else if (state == TPS_IMPOSS && sync_c.fault_clear) begin
            impossible_fault <= 1'b0;
        end
    end

    property p_load_clutch;
        @(posedge core_clk) disable iff (!rstn)
        (state == TPS_IDLE && next_state == TPS_WAIT_RC) |=> drive.reader_clutch && print_code_register == $past(q_code);
    endproperty
    a_load_clutch: assert property (p_load_clutch) else $error("code not loaded"); // [RQ1]

    property p_rc_drive;
        @(posedge core_clk) disable iff (!rstn)
        (state == TPS_WAIT_RC && rc_rise) |=> drive.char_ack && drive.detect_en && drive.translator_clutch;
    endproperty
    a_rc_drive: assert property (p_rc_drive) else $error("no translator drive"); // [RQ3]

    property p_invalid;
        @(posedge core_clk) disable iff (!rstn)
        (state == TPS_CLASSIFY && !is_valid) |=> state == TPS_IMPOSS && impossible_fault && !drive.reader_clutch;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid code missed"); // [RQ5]

    property p_func;
        @(posedge core_clk) disable iff (!rstn)
        (state == TPS_CLASSIFY && is_valid && is_func) |=> state == TPS_FUNC && function_state;
    endproperty
    a_func: assert property (p_func) else $error("function path missed"); // [RQ11]

    property p_rc_open;
        @(posedge core_clk) disable iff (!rstn)
        rc_fall |=> !drive.char_ack && !drive.detect_en && !drive.translator_clutch;
    endproperty
    a_rc_open: assert property (p_rc_open) else $error("drive not dropped"); // [RQ9]

    property p_no_pulse_fault;
        @(posedge core_clk) disable iff (!rstn)
        impossible_fault |-> !typewriter_done_pulse && drive.ack1;
    endproperty
    a_no_pulse_fault: assert property (p_no_pulse_fault) else $error("pulse during fault"); // [RQ14]

    property p_pulse_single;
        @(posedge core_clk) disable iff (!rstn)
        typewriter_done_pulse |=> !typewriter_done_pulse;
    endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("pulse too long"); // [RQ10]

    property p_hold_fault;
        @(posedge core_clk) disable iff (!rstn)
        impossible_fault |=> !drive.reader_clutch && print_code_register == $past(print_code_register);
    endproperty
    a_hold_fault: assert property (p_hold_fault) else $error("command taken in fault"); // [RQ16]

    property p_ack_drop;
        @(posedge core_clk) disable iff (!rstn)
        (state == TPS_CHAR && drive.char_ack && drive.ack1) |=> !drive.ack1 && !drive.reader_clutch;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("ack I not dropped"); // [RQ7]

    property p_char_path;
        @(posedge core_clk) disable iff (!rstn)
        (state == TPS_CLASSIFY && is_valid && !is_func) |=> state == TPS_CHAR && !function_state;
    endproperty
    a_char_path: assert property (p_char_path) else $error("character path missed"); // [RQ6]

    property p_clutch_cmd;
        @(posedge core_clk) disable iff (!rstn)
        $rose(drive.reader_clutch) |-> $past(q_valid && q_ready);
    endproperty
    a_clutch_cmd: assert property (p_clutch_cmd) else $error("cycle without command"); // [RQ8]

    property p_done_pulse;
        @(posedge core_clk) disable iff (!rstn)
        (state == TPS_CHAR && char_ack_dropped) |=> typewriter_done_pulse && drive.ack1 && drive.ack2;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("no completion pulse"); // [RQ10]

    property p_func_block;
        @(posedge core_clk) disable iff (!rstn)
        function_state |-> !typewriter_done_pulse;
    endproperty
    a_func_block: assert property (p_func_block) else $error("pulse while function held"); // [RQ12]

    property p_ack_hold;
        @(posedge core_clk) disable iff (!rstn)
        (state == TPS_FUNC && !drive.ack1 && !(char_ack_dropped && cr_opened && cr_rise)) |=> !drive.ack1;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack I returned early"); // [RQ13]

    property p_fault_state;
        @(posedge core_clk) disable iff (!rstn)
        state == TPS_IMPOSS |-> impossible_fault;
    endproperty
    a_fault_state: assert property (p_fault_state) else $error("fault not raised"); // [RQ15]

    c_char: cover property (@(posedge core_clk) disable iff (!rstn) state == TPS_CHAR ##[1:50] typewriter_done_pulse);
    c_func: cover property (@(posedge core_clk) disable iff (!rstn) state == TPS_FUNC ##[1:50] state == TPS_DONE);
    c_imp: cover property (@(posedge core_clk) disable iff (!rstn) state == TPS_IMPOSS ##[1:50] state == TPS_IDLE);
    c_full: cover property (@(posedge core_clk) disable iff (!rstn) !fifo_in_ready && q_valid ##1 fifo_in_ready);
endmodule
`default_nettype wire

// ---- tps_typewriter_model.sv ----
// behavioural typewriter: reader common and carriage return contacts
`timescale 1ns/1ps
`default_nettype none
module tps_typewriter_model import tps_pkg::*; (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] lag,
    input wire tps_drive_t drive,
    input wire logic [5:0] print_code_register,
    output logic reader_common,
    output logic cr_contact
);
    logic fn;

    initial begin
        reader_common = 1'b0;
        cr_contact = 1'b1;
        fn = 1'b0;
        forever begin
            // a cycle starts only while the clutch is engaged
            do @(posedge core_clk); while (!(rstn === 1'b1 && drive.reader_clutch === 1'b1));
            fn = (print_code_register == TPS_CODE_CR) || (print_code_register == TPS_CODE_TAB);
            repeat (lag) @(posedge core_clk);
            reader_common <= 1'b1; // cycle start closes common contacts
            do @(posedge core_clk); while (drive.reader_clutch === 1'b1);
            repeat (lag + 1) @(posedge core_clk);
            reader_common <= 1'b0;
            if (fn) begin
                // carriage moves: contact opens, then closes again
                repeat (lag + 1) @(posedge core_clk);
                cr_contact <= 1'b0;
                repeat (lag + 1) @(posedge core_clk);
                cr_contact <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tps_tb.sv ----
// self-checking testbench for the typewriter print sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench import tps_pkg::*; ;
    logic core_clk, rstn, print_cmd_valid, print_cmd_ready, rc, cr, fc, clutch_q;
    logic typewriter_done_pulse, impossible_fault, function_state;
    logic [5:0] x_code, print_code_register;
    logic [7:0] lag;
    tps_contacts_t contacts;
    tps_drive_t drive;
    int failures = 0;
    int total_checks = 0;
    int pulses = 0;
    int rises = 0;
    int i, k, p0, r0, acc, n;

    assign contacts = {rc, cr, fc};

    tps_sequencer dut (.core_clk(core_clk), .rstn(rstn), .print_cmd_valid(print_cmd_valid),
        .print_cmd_ready(print_cmd_ready), .x_code(x_code), .contacts(contacts), .drive(drive),
        .print_code_register(print_code_register), .typewriter_done_pulse(typewriter_done_pulse),
        .impossible_fault(impossible_fault), .function_state(function_state));
    tps_typewriter_model partner (.core_clk(core_clk), .rstn(rstn), .lag(lag), .drive(drive),
        .print_code_register(print_code_register), .reader_common(rc), .cr_contact(cr));

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk);
    endtask

    task automatic push(input logic [5:0] c);
        int w;
        w = 0;
        @(posedge core_clk);
        print_cmd_valid <= 1'b1;
        x_code <= c;
        do begin
            @(posedge core_clk);
            w++;
        end while (print_cmd_ready !== 1'b1 && w < 5000);
        print_cmd_valid <= 1'b0;
    endtask

    always @(posedge core_clk) begin
        if (typewriter_done_pulse === 1'b1) begin
            pulses++;
            check(function_state, 1'h0);
        end
        if (drive.reader_clutch === 1'b1 && !clutch_q) rises++;
        clutch_q = (drive.reader_clutch === 1'b1);
    end

    // kind: 0 character, 1 function, 2 impossible print
    task automatic run_cmd(input logic [5:0] c, input int kind);
        int w, q0;
        q0 = pulses;
        push(c);
        for (w = 0; w < 50 && drive.reader_clutch !== 1'b1; w++) @(posedge core_clk);
        check(print_code_register, c);
        for (w = 0; w < 200 && drive.char_ack !== 1'b1; w++) @(posedge core_clk);
        check({drive.translator_clutch, drive.solenoids, drive.detect_en}, 3'h7);
        if (kind == 2) begin
            for (w = 0; w < 20 && impossible_fault !== 1'b1; w++) @(posedge core_clk);
            check(impossible_fault, 1'h1);
            cyc(1);
            check({drive.reader_clutch, drive.ack1, print_code_register}, {1'b0, 1'b1, c});
            cyc(40);
            check(pulses, q0);
            check({impossible_fault, drive.reader_clutch}, 2'h2);
        end else begin
            for (w = 0; w < 200 && drive.ack1 !== 1'b0; w++) @(posedge core_clk);
            check({drive.reader_clutch, drive.ack2, print_code_register}, 8'h00);
            check(function_state, kind == 1);
            for (w = 0; w < 400 && pulses == q0; w++) @(posedge core_clk);
            cyc(2);
            check({drive.ack1, drive.ack2, function_state}, 3'h6);
            check({drive.translator_clutch, drive.char_ack, drive.detect_en}, 3'h0);
            cyc(10);
            check(pulses - q0, 1);
            check(drive.reader_clutch, 1'h0);
        end
    endtask

    task automatic clear_fault;
        int w;
        w = 0;
        @(posedge core_clk);
        fc <= 1'b1;
        do begin
            @(posedge core_clk);
            w++;
        end while (impossible_fault === 1'b1 && w < 50);
        fc <= 1'b0;
        cyc(4);
        check({impossible_fault, drive.ack1}, 2'h1);
    endtask

    initial begin
        rstn = 1'b0;
        print_cmd_valid = 1'b0;
        x_code = 6'h00;
        fc = 1'b0;
        lag = 8'h01;
        clutch_q = 1'b0;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        check(drive, 7'h06);
        check({print_code_register, typewriter_done_pulse, impossible_fault, function_state}, 9'h000);
        // every code, sorted into its path, with prompt and slow contacts
        for (i = 0; i < 64; i++) begin
            lag <= 8'((i % 3) * 2 + 1);
            if (6'(i) inside {6'h00, 6'h08, 6'h20, 6'h21, 6'h23, 6'h2b, 6'h2d, 6'h33, 6'h35,
                    6'h37, 6'h39, 6'h3b, 6'h3d, 6'h3e, 6'h3f}) k = 2;
            else if (6'(i) == TPS_CODE_CR || 6'(i) == TPS_CODE_TAB) k = 1;
            else k = 0;
            run_cmd(6'(i), k);
            if (k == 2) clear_fault;
        end
        // a command queued during a fault waits for the clear
        run_cmd(6'h3f, 2);
        push(6'h18);
        cyc(30);
        check(drive.reader_clutch, 1'h0);
        p0 = pulses;
        clear_fault;
        for (n = 0; n < 400 && pulses == p0; n++) @(posedge core_clk);
        check(pulses - p0, 1);
        // fill the queue against a slow typewriter, then drain it
        lag <= 8'h14;
        p0 = pulses;
        r0 = rises;
        acc = 0;
        @(posedge core_clk);
        print_cmd_valid <= 1'b1;
        x_code <= 6'h01;
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk);
            if (print_cmd_ready === 1'b1) acc++;
            else if (acc > 0) break;
            x_code <= (acc % 2 == 1) ? 6'h18 : 6'h01;
        end
        print_cmd_valid <= 1'b0;
        check(acc >= 32, 1);
        for (n = 0; n < 20000 && pulses - p0 < acc; n++) @(posedge core_clk);
        cyc(20);
        check(pulses - p0, acc);
        check(rises - r0, acc);
        check(print_cmd_ready, 1'h1);
        results;
    end

    initial begin
        #900000;
        failures++;
        results;
    end
endmodule
`default_nettype wire
